// ===== src/rfx_core_regs.sv
// condition flags, 64-byte stack pointer, program counter, context sequencer
// assumes a stack memory that returns read data the cycle after mem_re_o

`timescale 1ns/100ps

module rfx_core_regs (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic alu_valid_i,
	input wire rfx_pkg::rfx_alu_t alu_op_i,
	input wire logic [7:0] alu_a_i,
	input wire logic [7:0] alu_b_i,
	input wire logic [7:0] alu_res_i,
	input wire logic alu_carry_i,
	input wire logic set_carry_instr_i,
	input wire logic clear_carry_instr_i,
	input wire logic set_mask_i,
	input wire logic clr_mask_i,
	input wire logic cc_wr_i,
	input wire logic [7:0] cc_wdata_i,
	input wire logic sp_wr_i,
	input wire logic [7:0] sp_wdata_i,
	input wire logic reset_stack_instr_i,
	input wire logic pc_load_i,
	input wire logic [15:0] pc_next_i,
	input wire logic boundary_i,
	input wire logic irq_req_i,
	input wire logic [15:0] irq_vec_i,
	input wire logic trap_i,
	input wire logic call_i,
	input wire logic ret_i,
	input wire logic interrupt_return_instr_i,
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic stk_cc_i,
	input wire logic [7:0] push_data_i,
	input wire logic [7:0] acc_i,
	input wire logic [7:0] idx_x_i,
	input wire logic [7:0] mem_rdata_i,
	output logic [7:0] condition_flags_o,
	output logic [15:0] stack_pointer_o,
	output logic [15:0] program_counter_o,
	output logic busy_o,
	output logic irq_pend_o,
	output logic irq_ack_o,
	output logic [15:0] mem_addr_o,
	output logic [7:0] mem_wdata_o,
	output logic mem_we_o,
	output logic mem_re_o,
	output logic [7:0] pop_data_o,
	output logic pop_valid_o,
	output logic [7:0] acc_o,
	output logic acc_load_o,
	output logic [7:0] idx_x_o,
	output logic idx_x_load_o
);
	import rfx_pkg::*;

	// ****************************************
	// sequence tables
	// ****************************************
	function automatic rfx_byte_t seq_byte(input rfx_seq_t s,
			input logic [2:0] i, input logic use_cc);
		case (s)
			SEQ_IRQ, SEQ_CALL: begin
				case (i)
					3'h0: seq_byte = B_PCL;
					3'h1: seq_byte = B_PCH;
					3'h2: seq_byte = B_X;
					3'h3: seq_byte = B_A;
					default: seq_byte = B_CC;
				endcase
			end
			SEQ_INTERRUPT_RETURN_INSTR: begin
				case (i)
					3'h0: seq_byte = B_CC;
					3'h1: seq_byte = B_A;
					3'h2: seq_byte = B_X;
					3'h3: seq_byte = B_PCH;
					default: seq_byte = B_PCL;
				endcase
			end
			SEQ_RET: seq_byte = (i == 3'h0) ? B_PCH : B_PCL;
			SEQ_VEC: seq_byte = (i == 3'h0) ? B_VHI : B_VLO;
			default: seq_byte = use_cc ? B_CC : B_DATA;
		endcase
	endfunction : seq_byte

	function automatic logic [2:0] seq_last(input rfx_seq_t s);
		case (s)
			SEQ_IRQ, SEQ_INTERRUPT_RETURN_INSTR: seq_last = RFX_CTX_LAST;
			SEQ_CALL, SEQ_RET, SEQ_VEC: seq_last = RFX_PAIR_LAST;
			default: seq_last = RFX_ONE_LAST;
		endcase
	endfunction : seq_last

	function automatic logic [5:0] sp_step(input logic [5:0] low,
			input logic dec);
		// six-bit arithmetic wraps on its own, no overflow flag kept
		sp_step = dec ? low - RFX_SP_STEP : low + RFX_SP_STEP;
	endfunction : sp_step

	// ****************************************
	// shared decode
	// ****************************************
	rfx_state_t state;
	rfx_seq_t seq;
	logic [2:0] idx;
	logic op_cc;
	logic [7:0] data_q;
	logic [15:0] vec_base;
	logic [7:0] next_cc;
	logic mask_eff;
	logic take_trap;
	logic take_irq;
	logic take_any;
	logic push_stb;
	logic rd_stb;
	logic cap_stb;
	logic stack_rd;
	logic cc_restore;
	rfx_byte_t cur_byte;
	logic [7:0] push_byte;
	logic [15:0] rd_addr;
	logic add_cin;
	logic is_add;
	logic [8:0] sum9;
	logic [4:0] half5;
	logic [7:0] alu_out;

	// software clearing the mask this cycle opens the gate at once
	assign mask_eff = condition_flags_o[RFX_CC_I] & ~clr_mask_i;
	assign take_trap = (state == ST_IDLE) & trap_i;
	assign take_irq = (state == ST_IDLE) & boundary_i & irq_pend_o
		& ~mask_eff & ~trap_i;
	assign take_any = take_trap | take_irq;
	assign push_stb = (state == ST_PUSH);
	assign rd_stb = (state == ST_RD);
	assign cap_stb = (state == ST_RDC);
	assign stack_rd = (seq != SEQ_VEC);
	assign cur_byte = seq_byte(seq, idx, op_cc);
	assign cc_restore = cap_stb & (cur_byte == B_CC);
	assign rd_addr = stack_rd
		? {stack_pointer_o[15:RFX_SP_BITS],
			sp_step(stack_pointer_o[5:0], 1'b0)}
		: vec_base + {13'h0000, idx};

	// second index register has no path onto the stack at all
	always_comb begin
		case (cur_byte)
			B_PCL: push_byte = program_counter_o[7:0];
			B_PCH: push_byte = program_counter_o[15:8];
			B_X: push_byte = idx_x_i;
			B_A: push_byte = acc_i;
			B_CC: push_byte = condition_flags_o;
			default: push_byte = data_q;
		endcase
	end

	// ****************************************
	// alu flags
	// ****************************************
	assign add_cin = (alu_op_i == ALU_ADC) & condition_flags_o[RFX_CC_C];
	assign is_add = (alu_op_i == ALU_ADD) | (alu_op_i == ALU_ADC);
	assign sum9 = {1'b0, alu_a_i} + {1'b0, alu_b_i} + {8'h00, add_cin};
	assign half5 = {1'b0, alu_a_i[RFX_NIB_MSB:0]}
		+ {1'b0, alu_b_i[RFX_NIB_MSB:0]} + {4'h0, add_cin};
	assign alu_out = is_add ? sum9[RFX_BYTE_MSB:0] : alu_res_i;

	always_comb begin
		next_cc = condition_flags_o;
		if (alu_valid_i) begin
			case (alu_op_i)
				ALU_ADD, ALU_ADC: begin
					next_cc[RFX_CC_H] = half5[RFX_NIB_MSB + 1];
					next_cc[RFX_CC_C] = sum9[RFX_SUM_CARRY];
				end
				ALU_ARITH, ALU_SHIFT, ALU_BTJ: begin
					next_cc[RFX_CC_C] = alu_carry_i;
				end
				default: begin
				end
			endcase
			if (alu_op_i != ALU_BTJ) begin
				next_cc[RFX_CC_N] = alu_out[RFX_BYTE_MSB];
				next_cc[RFX_CC_Z] = (alu_out == 8'h00);
			end
		end
		if (clear_carry_instr_i)
			next_cc[RFX_CC_C] = 1'b0;
		if (set_carry_instr_i)
			next_cc[RFX_CC_C] = 1'b1;
		if (cc_wr_i)
			next_cc = {RFX_CC_ONES, cc_wdata_i[RFX_CC_H:0]};
		if (cc_restore) begin
			next_cc = {RFX_CC_ONES, mem_rdata_i[RFX_CC_H:0]};
			if (seq == SEQ_INTERRUPT_RETURN_INSTR)
				next_cc[RFX_CC_I] = 1'b0;
		end
		if (clr_mask_i)
			next_cc[RFX_CC_I] = 1'b0;
		// a set in the same cycle beats the clear
		if (set_mask_i | take_any)
			next_cc[RFX_CC_I] = 1'b1;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i)
			condition_flags_o <= RFX_CC_RST;
		else if (ce_i)
			condition_flags_o <= next_cc;
	end

	// ****************************************
	// pending request latch
	// ****************************************
	always_ff @(posedge mclk_i) begin
		if (srst_i)
			irq_pend_o <= 1'b0;
		else if (ce_i) begin
			if (irq_req_i)
				irq_pend_o <= 1'b1;
			else if (take_irq)
				irq_pend_o <= 1'b0;
		end
	end

	// ****************************************
	// stack pointer
	// ****************************************
	always_ff @(posedge mclk_i) begin
		if (srst_i)
			stack_pointer_o <= RFX_SP_RST;
		else if (ce_i) begin
			// upper ten bits are never assigned after reset
			if (push_stb)
				stack_pointer_o[5:0] <=
					sp_step(stack_pointer_o[5:0], 1'b1);
			else if (rd_stb & stack_rd)
				stack_pointer_o[5:0] <=
					sp_step(stack_pointer_o[5:0], 1'b0);
			else if (reset_stack_instr_i)
				stack_pointer_o[5:0] <= RFX_SP_TOP;
			else if (sp_wr_i)
				stack_pointer_o[5:0] <= sp_wdata_i[5:0];
		end
	end

	// ****************************************
	// program counter
	// ****************************************
	always_ff @(posedge mclk_i) begin
		if (srst_i)
			program_counter_o <= RFX_PC_RST;
		else if (ce_i) begin
			if (cap_stb) begin
				if (cur_byte == B_VHI || cur_byte == B_PCH)
					program_counter_o[15:8] <= mem_rdata_i;
				else if (cur_byte == B_VLO || cur_byte == B_PCL)
					program_counter_o[7:0] <= mem_rdata_i;
			end else if (pc_load_i && state == ST_IDLE)
				program_counter_o <= pc_next_i;
		end
	end

	// ****************************************
	// context sequencer
	// ****************************************
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			// first action after reset is the vector fetch
			state <= ST_RD;
			seq <= SEQ_VEC;
			idx <= RFX_IDX_FIRST;
			vec_base <= RFX_RESET_VEC;
			op_cc <= 1'b0;
			data_q <= 8'h00;
			busy_o <= 1'b1;
			irq_ack_o <= 1'b0;
		end else if (ce_i) begin
			irq_ack_o <= 1'b0;
			case (state)
				ST_IDLE: begin
					idx <= RFX_IDX_FIRST;
					op_cc <= stk_cc_i;
					data_q <= push_data_i;
					if (take_any) begin
						seq <= SEQ_IRQ;
						vec_base <= take_trap ? RFX_TRAP_VEC : irq_vec_i;
						state <= ST_PUSH;
						busy_o <= 1'b1;
						irq_ack_o <= 1'b1;
					end else if (call_i) begin
						seq <= SEQ_CALL;
						state <= ST_PUSH;
						busy_o <= 1'b1;
					end else if (push_i) begin
						seq <= SEQ_PUSH;
						state <= ST_PUSH;
						busy_o <= 1'b1;
					end else if (interrupt_return_instr_i) begin
						seq <= SEQ_INTERRUPT_RETURN_INSTR;
						state <= ST_RD;
						busy_o <= 1'b1;
					end else if (ret_i) begin
						seq <= SEQ_RET;
						state <= ST_RD;
						busy_o <= 1'b1;
					end else if (pop_i) begin
						seq <= SEQ_POP;
						state <= ST_RD;
						busy_o <= 1'b1;
					end
				end
				ST_PUSH: begin
					if (idx == seq_last(seq)) begin
						idx <= RFX_IDX_FIRST;
						if (seq == SEQ_IRQ) begin
							seq <= SEQ_VEC;
							state <= ST_RD;
						end else begin
							state <= ST_IDLE;
							busy_o <= 1'b0;
						end
					end else
						idx <= idx + RFX_IDX_STEP;
				end
				ST_RD: state <= ST_RDW;
				ST_RDW: state <= ST_RDC;
				ST_RDC: begin
					if (idx == seq_last(seq)) begin
						state <= ST_IDLE;
						busy_o <= 1'b0;
					end else begin
						idx <= idx + RFX_IDX_STEP;
						state <= ST_RD;
					end
				end
				default: begin
					state <= ST_IDLE;
					busy_o <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// memory strobes
	// ****************************************
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			mem_we_o <= 1'b0;
			mem_re_o <= 1'b0;
			mem_addr_o <= 16'h0000;
			mem_wdata_o <= 8'h00;
		end else if (ce_i) begin
			mem_we_o <= push_stb;
			mem_re_o <= rd_stb;
			if (push_stb) begin
				mem_addr_o <= stack_pointer_o;
				mem_wdata_o <= push_byte;
			end else if (rd_stb)
				mem_addr_o <= rd_addr;
		end
	end

	// ****************************************
	// restored context
	// ****************************************
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			acc_o <= 8'h00;
			acc_load_o <= 1'b0;
			idx_x_o <= 8'h00;
			idx_x_load_o <= 1'b0;
			pop_data_o <= 8'h00;
			pop_valid_o <= 1'b0;
		end else if (ce_i) begin
			acc_load_o <= cap_stb & (cur_byte == B_A);
			idx_x_load_o <= cap_stb & (cur_byte == B_X);
			pop_valid_o <= cap_stb & (cur_byte == B_DATA);
			if (cap_stb && cur_byte == B_A)
				acc_o <= mem_rdata_i;
			if (cap_stb && cur_byte == B_X)
				idx_x_o <= mem_rdata_i;
			if (cap_stb && cur_byte == B_DATA)
				pop_data_o <= mem_rdata_i;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	property p_half;
		@(posedge mclk_i) disable iff (srst_i)
		ce_i && alu_valid_i && is_add && !cc_wr_i && !cap_stb
		|=> condition_flags_o[RFX_CC_H] == $past(half5[4]);
	endproperty
	a_half: assert property (p_half)
		else $error("half carry wrong after add");

	property p_neg_zero;
		@(posedge mclk_i) disable iff (srst_i)
		ce_i && alu_valid_i && alu_op_i != ALU_BTJ && !cc_wr_i && !cap_stb
		|=> condition_flags_o[RFX_CC_N] == $past(alu_out[7])
			&& condition_flags_o[RFX_CC_Z] == ($past(alu_out) == 8'h00);
	endproperty
	a_neg_zero: assert property (p_neg_zero)
		else $error("negative or zero flag wrong");

	property p_set_carry;
		@(posedge mclk_i) disable iff (srst_i)
		ce_i && set_carry_instr_i && !cc_wr_i && !cap_stb
		|=> condition_flags_o[RFX_CC_C];
	endproperty
	a_set_carry: assert property (p_set_carry)
		else $error("set carry lost");

	property p_entry_mask;
		@(posedge mclk_i) disable iff (srst_i)
		ce_i && take_any |=> condition_flags_o[RFX_CC_I] ##0 irq_ack_o;
	endproperty
	a_entry_mask: assert property (p_entry_mask)
		else $error("mask not set on entry");

	property p_interrupt_return_instr_unmask;
		@(posedge mclk_i) disable iff (srst_i)
		ce_i && cc_restore && seq == SEQ_INTERRUPT_RETURN_INSTR && !set_mask_i
		|=> !condition_flags_o[RFX_CC_I];
	endproperty
	a_interrupt_return_instr_unmask: assert property (p_interrupt_return_instr_unmask)
		else $error("return left mask set");

	property p_pending;
		@(posedge mclk_i) disable iff (srst_i)
		ce_i && irq_req_i |=> irq_pend_o;
	endproperty
	a_pending: assert property (p_pending)
		else $error("request not held pending");

	property p_fixed_bits;
		@(posedge mclk_i) disable iff (srst_i)
		condition_flags_o[7:RFX_CC_TOP] == RFX_CC_ONES
			&& stack_pointer_o[15:6] == RFX_SP_RST[15:6];
	endproperty
	a_fixed_bits: assert property (p_fixed_bits)
		else $error("fixed bits changed");

	property p_first_pcl;
		@(posedge mclk_i) disable iff (srst_i)
		irq_ack_o && ce_i |=> mem_we_o
			&& mem_wdata_o == $past(program_counter_o[7:0])
			&& mem_addr_o == $past(stack_pointer_o);
	endproperty
	a_first_pcl: assert property (p_first_pcl)
		else $error("entry did not write pc low first at sp");

	property p_five_bytes;
		@(posedge mclk_i) disable iff (srst_i)
		(irq_ack_o && ce_i) ##1 ce_i [*5]
		|-> stack_pointer_o[5:0] == $past(stack_pointer_o[5:0], 6) - 6'h05;
	endproperty
	a_five_bytes: assert property (p_five_bytes)
		else $error("interrupt did not take five bytes");

	property p_rsp;
		@(posedge mclk_i) disable iff (srst_i)
		ce_i && reset_stack_instr_i && state == ST_IDLE
		|=> stack_pointer_o == RFX_SP_RST;
	endproperty
	a_rsp: assert property (p_rsp)
		else $error("reset stack did not load top");

endmodule : rfx_core_regs

// ===== src/rfx_pkg.sv
// constants and types of the cpu flag, stack pointer and program counter file
// assumes nothing beyond a SystemVerilog compiler

package rfx_pkg;

	// ****************************************
	// vectors and reset values
	// ****************************************
	localparam logic [15:0] RFX_RESET_VEC = 16'hFFFE;
	localparam logic [15:0] RFX_TRAP_VEC = 16'hFFFC;
	localparam logic [15:0] RFX_PC_RST = 16'h0000;
	localparam logic [15:0] RFX_SP_RST = 16'h013F;
	localparam logic [7:0] RFX_CC_RST = 8'hE8;

	// ****************************************
	// field layout
	// ****************************************
	localparam int RFX_SP_BITS = 6;
	localparam logic [5:0] RFX_SP_TOP = 6'h3F;
	localparam logic [5:0] RFX_SP_STEP = 6'h01;
	localparam int RFX_CC_C = 0;
	localparam int RFX_CC_Z = 1;
	localparam int RFX_CC_N = 2;
	localparam int RFX_CC_I = 3;
	localparam int RFX_CC_H = 4;
	localparam int RFX_CC_TOP = 5;
	localparam logic [2:0] RFX_CC_ONES = 3'h7;
	localparam int RFX_NIB_MSB = 3;
	localparam int RFX_BYTE_MSB = 7;
	localparam int RFX_SUM_CARRY = 8;

	// ****************************************
	// sequence lengths, as last byte index
	// ****************************************
	localparam logic [2:0] RFX_IDX_FIRST = 3'h0;
	localparam logic [2:0] RFX_IDX_STEP = 3'h1;
	localparam logic [2:0] RFX_CTX_LAST = 3'h4;
	localparam logic [2:0] RFX_PAIR_LAST = 3'h1;
	localparam logic [2:0] RFX_ONE_LAST = 3'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PUSH = 3'b001,
		ST_RD = 3'b010,
		ST_RDW = 3'b011,
		ST_RDC = 3'b100
	} rfx_state_t;

	typedef enum logic [2:0] {
		SEQ_IRQ = 3'b000,
		SEQ_CALL = 3'b001,
		SEQ_PUSH = 3'b010,
		SEQ_INTERRUPT_RETURN_INSTR = 3'b011,
		SEQ_RET = 3'b100,
		SEQ_POP = 3'b101,
		SEQ_VEC = 3'b110
	} rfx_seq_t;

	typedef enum logic [2:0] {
		B_PCL = 3'b000,
		B_PCH = 3'b001,
		B_X = 3'b010,
		B_A = 3'b011,
		B_CC = 3'b100,
		B_DATA = 3'b101,
		B_VHI = 3'b110,
		B_VLO = 3'b111
	} rfx_byte_t;

	typedef enum logic [2:0] {
		ALU_ADD = 3'b000,
		ALU_ADC = 3'b001,
		ALU_LOGIC = 3'b010,
		ALU_ARITH = 3'b011,
		ALU_SHIFT = 3'b100,
		ALU_BTJ = 3'b101
	} rfx_alu_t;

endpackage : rfx_pkg

// ===== testbench/tb.sv
// self-checking bench for the flag, stack pointer and program counter file
// assumes the core's one-cycle stack memory, modelled here by the bench
`timescale 1ns/100ps

module tb;
	import rfx_pkg::*;

	// ****************************************
	// stimulus and observed signals
	// ****************************************
	localparam int T_HALF = 25;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic ce_i = 1'b1;
	logic boundary_i = 1'b1;
	logic [15:0] str = 16'h0000;
	rfx_alu_t alu_op_i = ALU_ADD;
	logic [7:0] alu_a_i = 8'h00;
	logic [7:0] alu_b_i = 8'h00;
	logic [7:0] alu_res_i = 8'h00;
	logic alu_carry_i = 1'b0;
	logic [7:0] cc_wdata_i = 8'h00;
	logic [7:0] sp_wdata_i = 8'h00;
	logic [15:0] pc_next_i = 16'h0000;
	logic [15:0] irq_vec_i = 16'h2000;
	logic stk_cc_i = 1'b0;
	logic [7:0] push_data_i = 8'h00;
	logic [7:0] acc_i = 8'h3C;
	logic [7:0] idx_x_i = 8'hC3;
	logic [7:0] mem_rdata_i = 8'h00;
	wire set_carry_instr_i = str[0];
	wire clear_carry_instr_i = str[1];
	wire set_mask_i = str[2];
	wire clr_mask_i = str[3];
	wire cc_wr_i = str[4];
	wire sp_wr_i = str[5];
	wire reset_stack_instr_i = str[6];
	wire pc_load_i = str[7];
	wire irq_req_i = str[8];
	wire trap_i = str[9];
	wire call_i = str[10];
	wire ret_i = str[11];
	wire interrupt_return_instr_i = str[12];
	wire push_i = str[13];
	wire pop_i = str[14];
	wire alu_valid_i = str[15];
	logic [7:0] condition_flags_o;
	logic [15:0] stack_pointer_o;
	logic [15:0] program_counter_o;
	logic busy_o;
	logic irq_pend_o;
	logic irq_ack_o;
	logic [15:0] mem_addr_o;
	logic [7:0] mem_wdata_o;
	logic mem_we_o;
	logic mem_re_o;
	logic [7:0] pop_data_o;
	logic pop_valid_o;
	logic [7:0] acc_o;
	logic acc_load_o;
	logic [7:0] idx_x_o;
	logic idx_x_load_o;
	logic [7:0] mem [0:65535];
	int num_errors = 0;
	int compares = 0;
	int acks = 0;
	int pops = 0;
	int loads = 0;

	always #(T_HALF) mclk_i = ~mclk_i;

	rfx_core_regs i_dut (
		.mclk_i, .srst_i, .ce_i, .alu_valid_i, .alu_op_i, .alu_a_i,
		.alu_b_i, .alu_res_i, .alu_carry_i, .set_carry_instr_i,
		.clear_carry_instr_i, .set_mask_i, .clr_mask_i, .cc_wr_i,
		.cc_wdata_i, .sp_wr_i, .sp_wdata_i, .reset_stack_instr_i,
		.pc_load_i, .pc_next_i, .boundary_i, .irq_req_i, .irq_vec_i,
		.trap_i, .call_i, .ret_i, .interrupt_return_instr_i, .push_i,
		.pop_i, .stk_cc_i, .push_data_i, .acc_i, .idx_x_i, .mem_rdata_i,
		.condition_flags_o, .stack_pointer_o, .program_counter_o, .busy_o,
		.irq_pend_o, .irq_ack_o, .mem_addr_o, .mem_wdata_o, .mem_we_o,
		.mem_re_o, .pop_data_o, .pop_valid_o, .acc_o, .acc_load_o,
		.idx_x_o, .idx_x_load_o
	);

	// ****************************************
	// stack memory, one cycle read latency
	// ****************************************
	// idle read data toggles so a stale capture cannot pass by luck
	always @(posedge mclk_i) begin
		if (mem_we_o === 1'b1) begin
			mem[mem_addr_o] <= mem_wdata_o;
		end
		if (mem_re_o === 1'b1) begin
			mem_rdata_i <= mem[mem_addr_o];
		end else begin
			mem_rdata_i <= ~mem_rdata_i;
		end
		if (irq_ack_o === 1'b1) begin
			acks <= acks + 1;
		end
		if (pop_valid_o === 1'b1) begin
			pops <= pops + 1;
		end
		// accumulator and index restores never share a cycle
		if (acc_load_o === 1'b1 || idx_x_load_o === 1'b1) begin
			loads <= loads + 1;
		end
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk16

	// one-cycle strobe, then wait for the sequencer to go idle
	task automatic pulse(input int k);
		int n;
		str = 16'h0001 << k;
		@(posedge mclk_i);
		#1;
		str = 16'h0000;
		for (n = 0; n < 40 && busy_o !== 1'b0; n++) begin
			@(posedge mclk_i);
			#1;
		end
		// busy drops with the last write strobe; let it reach memory
		@(posedge mclk_i);
		#1;
		chk8({7'h00, busy_o}, 8'h00);
	endtask : pulse

	task automatic alu(input rfx_alu_t op, input logic [7:0] a, input logic
		[7:0] b, input logic [7:0] r, input logic c, input logic [7:0] e);
		alu_op_i = op;
		alu_a_i = a;
		alu_b_i = b;
		alu_res_i = r;
		alu_carry_i = c;
		pulse(15);
		chk8(condition_flags_o, e);
	endtask : alu

	task automatic report_and_stop;
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		#(T_HALF * 2 * 5000);
		num_errors++;
		report_and_stop();
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		int n;
		mem[16'hFFFE] = 8'h12;
		mem[16'hFFFF] = 8'h34;
		mem[16'h2000] = 8'hAB;
		mem[16'h2001] = 8'hCD;
		mem[16'hFFFC] = 8'h77;
		mem[16'hFFFD] = 8'h88;
		repeat (8) @(posedge mclk_i);
		#1;
		chk8(condition_flags_o, RFX_CC_RST);
		chk16(stack_pointer_o, 16'h013F);
		srst_i = 1'b0;
		for (n = 0; n < 40 && busy_o !== 1'b0; n++) begin
			@(posedge mclk_i);
			#1;
		end
		chk16(program_counter_o, 16'h1234);
		alu(ALU_ADD, 8'h0F, 8'h01, 8'h00, 1'b0, 8'hF8);
		alu(ALU_ADD, 8'h80, 8'h80, 8'h00, 1'b0, 8'hEB);
		alu(ALU_ADC, 8'h0F, 8'h00, 8'h00, 1'b0, 8'hF8);
		alu(ALU_LOGIC, 8'h00, 8'h00, 8'h80, 1'b0, 8'hFC);
		alu(ALU_SHIFT, 8'h00, 8'h00, 8'h00, 1'b1, 8'hFB);
		alu(ALU_BTJ, 8'h00, 8'h00, 8'h00, 1'b0, 8'hFA);
		pulse(0);
		chk8(condition_flags_o, 8'hFB);
		pulse(1);
		chk8(condition_flags_o, 8'hFA);
		alu(ALU_ARITH, 8'h00, 8'h00, 8'h7F, 1'b1, 8'hF9);
		// user stack: push and pop, both wrap directions
		push_data_i = 8'hA5;
		pulse(13);
		chk8(mem[16'h013F], 8'hA5);
		chk16(stack_pointer_o, 16'h013E);
		pulse(14);
		chk8(pop_data_o, 8'hA5);
		chk16(stack_pointer_o, 16'h013F);
		sp_wdata_i = 8'h00;
		pulse(5);
		chk16(stack_pointer_o, 16'h0100);
		push_data_i = 8'h5A;
		pulse(13);
		chk8(mem[16'h0100], 8'h5A);
		chk16(stack_pointer_o, 16'h013F);
		pulse(14);
		chk8(pop_data_o, 8'h5A);
		chk16(stack_pointer_o, 16'h0100);
		sp_wdata_i = 8'hFF;
		pulse(5);
		chk16(stack_pointer_o, 16'h013F);
		sp_wdata_i = 8'h05;
		pulse(5);
		pulse(6);
		chk16(stack_pointer_o, 16'h013F);
		stk_cc_i = 1'b1;
		pulse(13);
		chk8(mem[16'h013F], 8'hF9);
		stk_cc_i = 1'b0;
		cc_wdata_i = 8'h00;
		pulse(4);
		chk8(condition_flags_o, 8'hE0);
		stk_cc_i = 1'b1;
		pulse(14);
		stk_cc_i = 1'b0;
		chk8(condition_flags_o, 8'hF9);
		cc_wdata_i = 8'hFF;
		pulse(4);
		// subroutine call and return
		pc_next_i = 16'h4321;
		pulse(7);
		pulse(10);
		chk8(mem[16'h013F], 8'h21);
		chk8(mem[16'h013E], 8'h43);
		chk16(stack_pointer_o, 16'h013D);
		pc_next_i = 16'h5555;
		pulse(7);
		pulse(11);
		chk16(program_counter_o, 16'h4321);
		chk16(stack_pointer_o, 16'h013F);
		// masked request waits, taken when the mask clears
		pulse(8);
		chk8({7'h00, irq_pend_o}, 8'h01);
		chk16(16'(acks), 16'h0000);
		pulse(3);
		chk16(16'(acks), 16'h0001);
		chk8(mem[16'h013F], 8'h21);
		chk8(mem[16'h013E], 8'h43);
		chk8(mem[16'h013D], 8'hC3);
		chk8(mem[16'h013C], 8'h3C);
		chk8(mem[16'h013B] & 8'hF7, 8'hF7);
		chk16(stack_pointer_o, 16'h013A);
		chk16(program_counter_o, 16'hABCD);
		chk8(condition_flags_o & 8'h08, 8'h08);
		// second request inside the routine
		pulse(8);
		chk16(16'(acks), 16'h0001);
		pulse(3);
		chk16(16'(acks), 16'h0002);
		chk8(mem[16'h013A], 8'hCD);
		chk16(stack_pointer_o, 16'h0135);
		pulse(12);
		chk16(stack_pointer_o, 16'h013A);
		chk8(condition_flags_o & 8'h08, 8'h00);
		pulse(12);
		chk16(program_counter_o, 16'h4321);
		chk16(stack_pointer_o, 16'h013F);
		chk8(condition_flags_o, 8'hF7);
		chk8(acc_o, 8'h3C);
		chk8(idx_x_o, 8'hC3);
		// software trap ignores the mask
		pulse(2);
		chk8(condition_flags_o, 8'hFF);
		pulse(9);
		chk16(16'(acks), 16'h0003);
		chk16(program_counter_o, 16'h7788);
		pulse(12);
		chk16(program_counter_o, 16'h4321);
		chk16(stack_pointer_o, 16'h013F);
		chk16(16'(pops), 16'h0002);
		chk16(16'(loads), 16'h0006);
		// enable low must freeze the flags
		ce_i = 1'b0;
		pulse(1);
		chk8(condition_flags_o, 8'hF7);
		ce_i = 1'b1;
		pulse(1);
		chk8(condition_flags_o, 8'hF6);
		report_and_stop();
	end

endmodule : tb
